/* File: src/panel_pkg.sv */
// package: constants and types of the front panel display block
package panel_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned TICK_NS = 1_000_000;
    localparam int unsigned TICK_CYCLES = TICK_NS / (1_000_000_000 / CLK_HZ);
    localparam int unsigned SHOW_MS = 7_000;
    localparam int unsigned PAUSE_MS = 1_000;
    localparam int unsigned SCROLL_HOLD_MS = 180_000;
    localparam int unsigned IDLE_MS = 600_000;
    localparam int unsigned BLINK_ON_MS = 1_500;
    localparam int unsigned BLINK_OFF_MS = 500;
    localparam int unsigned PULSE_MIN_MS = 40;
    localparam int unsigned NUM_GROUPS = 8;
    localparam int unsigned MAX_SUBS = 5;
    localparam int unsigned BAR_SEGS = 10;
    // load thresholds in percent of full load
    localparam logic [7:0] BAR_PCT [BAR_SEGS] = '{8'h01, 8'h0f, 8'h1e, 8'h2d, 8'h3c,
                                                  8'h48, 8'h54, 8'h60, 8'h6c, 8'h78};
    localparam logic [7:0] OVERLOAD_PCT = 8'h78;
    // sub-reading counts per group, volts l-n first
    localparam logic [2:0] SUB_COUNT [NUM_GROUPS] = '{3'h4, 3'h3, 3'h5, 3'h4,
                                                      3'h3, 3'h4, 3'h4, 3'h1};
    // watt-hour per pulse constants, 30 fractional bits, fixed point
    localparam logic [31:0] WH_LOW_CL10 = 32'h1009_6f7a;
    localparam logic [31:0] WH_LOW_CL2 = 32'h0335_1e4c;
    localparam logic [31:0] WH_HIGH_CL10 = 32'h4025_bdea;
    localparam logic [31:0] WH_HIGH_CL2 = 32'h0cd4_7930;
    localparam logic [11:0] VOLT_SPLIT = 12'h096;
    // register space partitions
    localparam logic [15:0] FIXED_LO = 16'h0001;
    localparam logic [15:0] FIXED_HI = 16'h002f;
    localparam logic [15:0] READ_LO = 16'h03e8;
    localparam logic [15:0] READ_HI = 16'h138b;
    localparam logic [15:0] CMD_LO = 16'h4e20;
    localparam logic [15:0] CMD_HI = 16'h659b;
    localparam logic [15:0] PROG_LO = 16'h7530;
    localparam logic [15:0] PROG_HI = 16'h7573;
    localparam logic [15:0] SEC_LO = 16'h9c41;
    localparam logic [15:0] SEC_HI = 16'h9ca4;
    typedef enum logic [2:0] {
        SEC_NONE = 3'b000,
        SEC_FIXED = 3'b001,
        SEC_READ = 3'b010,
        SEC_CMD = 3'b011,
        SEC_PROG = 3'b100,
        SEC_SECOND = 3'b101
    } reg_section_e;
    typedef enum logic [1:0] {
        MODE_OPER = 2'b00,
        MODE_MENU = 2'b01,
        MODE_RESET = 2'b10,
        MODE_CONFIG = 2'b11
    } disp_mode_e;
endpackage : panel_pkg

/* File: src/word_pack_if.sv */
// interface: value to register word packing
`timescale 1ns/1ns
`default_nettype none
interface word_pack_if;
    logic [15:0] text_chars;
    logic [31:0] value32;
    logic [15:0] hi_word;
    logic [15:0] lo_word;
    logic [15:0] text_word;
    logic [15:0] reg_addr;
    panel_pkg::reg_section_e section;
    modport packer (input text_chars, value32, reg_addr, output hi_word, lo_word, text_word,
        section);
    modport user (output text_chars, value32, reg_addr, input hi_word, lo_word, text_word,
        section);
endinterface : word_pack_if
`default_nettype wire

/* File: src/word_packer.sv */
// module: packs values into 16-bit register words and decodes the section
`timescale 1ns/1ns
`default_nettype none
module word_packer (
    input wire logic core_clk,
    input wire logic rst,
    word_pack_if.packer wp
);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wp.text_word <= 16'h0000;
            wp.hi_word <= 16'h0000;
            wp.lo_word <= 16'h0000;
        end else begin
            wp.text_word <= {wp.text_chars[15:8], wp.text_chars[7:0]};
            wp.hi_word <= wp.value32[31:16];
            wp.lo_word <= wp.value32[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wp.section <= panel_pkg::SEC_NONE;
        end else if (wp.reg_addr >= panel_pkg::FIXED_LO && wp.reg_addr <= panel_pkg::FIXED_HI) begin
            wp.section <= panel_pkg::SEC_FIXED;
        end else if (wp.reg_addr >= panel_pkg::READ_LO && wp.reg_addr <= panel_pkg::READ_HI) begin
            wp.section <= panel_pkg::SEC_READ;
        end else if (wp.reg_addr >= panel_pkg::CMD_LO && wp.reg_addr <= panel_pkg::CMD_HI) begin
            wp.section <= panel_pkg::SEC_CMD;
        end else if (wp.reg_addr >= panel_pkg::PROG_LO && wp.reg_addr <= panel_pkg::PROG_HI) begin
            wp.section <= panel_pkg::SEC_PROG;
        end else if (wp.reg_addr >= panel_pkg::SEC_LO && wp.reg_addr <= panel_pkg::SEC_HI) begin
            wp.section <= panel_pkg::SEC_SECOND;
        end else begin
            wp.section <= panel_pkg::SEC_NONE;
        end
    end
endmodule : word_packer
`default_nettype wire

/* File: src/meter_front_panel_display.sv */
// module: front panel display sequencing, load bar and test pulse
`timescale 1ns/1ns
`default_nettype none
module meter_front_panel_display #(
    parameter int unsigned TICK_CYCLES = panel_pkg::TICK_CYCLES,
    parameter int unsigned SHOW_MS = panel_pkg::SHOW_MS,
    parameter int unsigned PAUSE_MS = panel_pkg::PAUSE_MS,
    parameter int unsigned SCROLL_HOLD_MS = panel_pkg::SCROLL_HOLD_MS,
    parameter int unsigned IDLE_MS = panel_pkg::IDLE_MS,
    parameter int unsigned BLINK_ON_MS = panel_pkg::BLINK_ON_MS,
    parameter int unsigned BLINK_OFF_MS = panel_pkg::BLINK_OFF_MS,
    parameter int unsigned PULSE_MIN_MS = panel_pkg::PULSE_MIN_MS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic btn_down,
    input wire logic btn_right,
    input wire logic btn_any,
    input wire logic mode_request,
    input wire logic [1:0] mode_select,
    input wire logic scroll_enable,
    input wire logic [7:0] group_enable,
    input wire logic [39:0] sub_enable,
    input wire logic [7:0] load_pct,
    input wire logic [11:0] input_volts,
    input wire logic class_two,
    input wire logic energy_quantum,
    input wire logic [15:0] text_chars,
    input wire logic [31:0] value32,
    input wire logic [15:0] reg_addr,
    output logic [1:0] disp_mode,
    output logic [2:0] active_group,
    output logic [2:0] active_sub,
    output logic disp_blank,
    output logic [7:0] group_lamp,
    output logic [9:0] load_bar,
    output logic test_pulse,
    output logic [31:0] watt_hour_per_pulse_constant,
    output logic [15:0] text_word,
    output logic [15:0] hi_word,
    output logic [15:0] lo_word,
    output logic [2:0] reg_section
);
    initial begin
        if (TICK_CYCLES < 2 || SHOW_MS < 1 || PAUSE_MS < 1 || PULSE_MIN_MS < 1 ||
            BLINK_ON_MS < 1 || BLINK_OFF_MS < 1 || SCROLL_HOLD_MS < 1 || IDLE_MS < 1) begin
            $error("timing parameters out of range");
        end
    end

    localparam int NG = panel_pkg::NUM_GROUPS;
    localparam int NS = panel_pkg::MAX_SUBS;

    // button synchronisers
    logic [2:0] btn_s1;
    logic [2:0] btn_s2;
    logic [2:0] btn_s3;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            btn_s1 <= 3'h0;
            btn_s2 <= 3'h0;
            btn_s3 <= 3'h0;
        end else begin
            btn_s1 <= {btn_any, btn_right, btn_down};
            btn_s2 <= btn_s1;
            btn_s3 <= btn_s2;
        end
    end
    logic down_press;
    logic right_press;
    logic any_press;
    assign down_press = btn_s2[0] && !btn_s3[0];
    assign right_press = btn_s2[1] && !btn_s3[1];
    assign any_press = (btn_s2 != 3'h0) && (btn_s3 == 3'h0 || btn_s2 != btn_s3);

    // millisecond tick
    logic [31:0] tick_cnt;
    logic tick;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tick_cnt <= 32'h0;
        end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
            tick_cnt <= 32'h0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end
    assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

    // display mode and inactivity return
    logic [31:0] idle_ms;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            idle_ms <= 32'h0;
        end else if (any_press || mode_request) begin
            idle_ms <= 32'h0;
        end else if (tick && idle_ms < 32'(IDLE_MS)) begin
            idle_ms <= idle_ms + 32'h1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            disp_mode <= panel_pkg::MODE_OPER;
        end else if (mode_request) begin
            disp_mode <= mode_select;
        end else if (disp_mode != panel_pkg::MODE_OPER && idle_ms >= 32'(IDLE_MS)) begin
            disp_mode <= panel_pkg::MODE_OPER;
        end
    end
    logic oper;
    assign oper = (disp_mode == panel_pkg::MODE_OPER);

    // scroll hold after a press
    logic [31:0] hold_ms;
    logic scroll_held;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hold_ms <= 32'h0;
            scroll_held <= 1'b0;
        end else if (any_press) begin
            hold_ms <= 32'h0;
            scroll_held <= 1'b1;
        end else if (scroll_held && tick) begin
            if (hold_ms >= 32'(SCROLL_HOLD_MS - 1)) begin
                scroll_held <= 1'b0;
            end else begin
                hold_ms <= hold_ms + 32'h1;
            end
        end
    end

    // next enabled group and sub-reading
    function automatic logic [2:0] next_group_of(input logic [2:0] cur, input logic [7:0] en);
        logic [2:0] g;
        logic found;
        g = cur;
        found = 1'b0;
        for (int i = 1; i <= NG; i++) begin
            if (!found && en[3'(cur + 3'(i))]) begin
                g = 3'(cur + 3'(i));
                found = 1'b1;
            end
        end
        return g;
    endfunction : next_group_of

    function automatic logic [2:0] next_sub_of(input logic [2:0] grp, input logic [2:0] cur,
        input logic [39:0] en);
        logic [2:0] s;
        logic [2:0] cand;
        logic [2:0] cnt;
        logic found;
        s = 3'h0;
        cnt = panel_pkg::SUB_COUNT[grp];
        found = 1'b0;
        for (int i = 1; i <= NS; i++) begin
            cand = 3'((int'(cur) + i) % int'(cnt));
            if (!found && en[int'(grp) * NS + int'(cand)]) begin
                s = cand;
                found = 1'b1;
            end
        end
        return s;
    endfunction : next_sub_of

    // scroll timer: show phase then blank pause
    logic [31:0] scroll_ms;
    logic scrolling;
    logic scroll_step;
    assign scrolling = oper && scroll_enable && !scroll_held;
    assign scroll_step = scrolling && tick && disp_blank && scroll_ms >= 32'(PAUSE_MS - 1);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            scroll_ms <= 32'h0;
            disp_blank <= 1'b0;
        end else if (!scrolling) begin
            scroll_ms <= 32'h0;
            disp_blank <= 1'b0;
        end else if (tick) begin
            if (!disp_blank && scroll_ms >= 32'(SHOW_MS - 1)) begin
                scroll_ms <= 32'h0;
                disp_blank <= 1'b1;
            end else if (disp_blank && scroll_ms >= 32'(PAUSE_MS - 1)) begin
                scroll_ms <= 32'h0;
                disp_blank <= 1'b0;
            end else begin
                scroll_ms <= scroll_ms + 32'h1;
            end
        end
    end

    // group and sub-reading navigation
    logic [2:0] next_group;
    logic [2:0] next_sub;
    assign next_group = next_group_of(active_group, group_enable);
    assign next_sub = next_sub_of(active_group, active_sub, sub_enable);
    logic [2:0] first_sub;
    assign first_sub = next_sub_of(next_group, 3'(panel_pkg::SUB_COUNT[next_group] - 3'h1),
        sub_enable);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            active_group <= 3'h0;
            active_sub <= 3'h0;
        end else if (oper && (down_press || scroll_step)) begin
            active_group <= next_group;
            active_sub <= first_sub;
        end else if (oper && right_press) begin
            active_sub <= next_sub;
        end
    end

    generate
        for (genvar g = 0; g < NG; g++) begin : g_lamp
            assign group_lamp[g] = oper && (active_group == 3'(g));
        end
    endgenerate

    // load bar with overload blink
    logic overload;
    logic blink_on;
    logic [31:0] blink_ms;
    assign overload = (load_pct > panel_pkg::OVERLOAD_PCT);
    always_ff @(posedge core_clk) begin
        if (rst || !overload) begin
            blink_ms <= 32'h0;
            blink_on <= 1'b1;
        end else if (tick) begin
            if (blink_on && blink_ms >= 32'(BLINK_ON_MS - 1)) begin
                blink_ms <= 32'h0;
                blink_on <= 1'b0;
            end else if (!blink_on && blink_ms >= 32'(BLINK_OFF_MS - 1)) begin
                blink_ms <= 32'h0;
                blink_on <= 1'b1;
            end else begin
                blink_ms <= blink_ms + 32'h1;
            end
        end
    end
    generate
        for (genvar s = 0; s < panel_pkg::BAR_SEGS; s++) begin : g_bar
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    load_bar[s] <= 1'b0;
                end else if (overload) begin
                    load_bar[s] <= blink_on;
                end else begin
                    load_bar[s] <= (load_pct >= panel_pkg::BAR_PCT[s]);
                end
            end
        end
    endgenerate

    // watt-hour per pulse constant selection
    always_ff @(posedge core_clk) begin
        if (rst) begin
            watt_hour_per_pulse_constant <= panel_pkg::WH_LOW_CL10;
        end else if (input_volts < panel_pkg::VOLT_SPLIT) begin
            watt_hour_per_pulse_constant <= class_two ? panel_pkg::WH_LOW_CL2
                : panel_pkg::WH_LOW_CL10;
        end else begin
            watt_hour_per_pulse_constant <= class_two ? panel_pkg::WH_HIGH_CL2
                : panel_pkg::WH_HIGH_CL10;
        end
    end

    // test pulse stretched to minimum width
    logic [31:0] pulse_cycles;
    localparam int unsigned PULSE_CYCLES = PULSE_MIN_MS * TICK_CYCLES;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            test_pulse <= 1'b0;
            pulse_cycles <= 32'h0;
        end else if (!test_pulse && energy_quantum) begin
            test_pulse <= 1'b1;
            pulse_cycles <= 32'h0;
        end else if (test_pulse) begin
            if (pulse_cycles >= 32'(PULSE_CYCLES - 1)) begin
                test_pulse <= 1'b0;
            end else begin
                pulse_cycles <= pulse_cycles + 32'h1;
            end
        end
    end

    // register word packing
    word_pack_if wp ();
    assign wp.text_chars = text_chars;
    assign wp.value32 = value32;
    assign wp.reg_addr = reg_addr;
    word_packer u_packer (
        .core_clk(core_clk),
        .rst(rst),
        .wp(wp.packer)
    );
    assign text_word = wp.text_word;
    assign hi_word = wp.hi_word;
    assign lo_word = wp.lo_word;
    assign reg_section = wp.section;
endmodule : meter_front_panel_display
`default_nettype wire

/* File: tb/panel_properties.sv */
// checker: port assertions of the front panel display
`timescale 1ns/1ns
`default_nettype none
module panel_properties #(
    parameter int unsigned TICK_CYCLES = 4,
    parameter int unsigned PULSE_MIN_MS = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic energy_quantum,
    input wire logic [7:0] load_pct,
    input wire logic [11:0] input_volts,
    input wire logic class_two,
    input wire logic [15:0] text_chars,
    input wire logic [31:0] value32,
    input wire logic [15:0] reg_addr,
    input wire logic [1:0] disp_mode,
    input wire logic [2:0] active_group,
    input wire logic disp_blank,
    input wire logic [7:0] group_lamp,
    input wire logic [9:0] load_bar,
    input wire logic test_pulse,
    input wire logic [31:0] watt_hour_per_pulse_constant,
    input wire logic [15:0] text_word,
    input wire logic [15:0] hi_word,
    input wire logic [15:0] lo_word,
    input wire logic [2:0] reg_section
);
    logic [31:0] hi_len;
    function automatic logic [9:0] therm(input logic [7:0] p);
        therm = '0;
        for (int s = 0; s < 10; s++) therm[s] = (p >= panel_pkg::BAR_PCT[s]);
    endfunction : therm
    function automatic logic [2:0] sect(input logic [15:0] a);
        sect = 3'h0;
        if (a >= panel_pkg::FIXED_LO && a <= panel_pkg::FIXED_HI) sect = 3'h1;
        if (a >= panel_pkg::READ_LO && a <= panel_pkg::READ_HI) sect = 3'h2;
        if (a >= panel_pkg::CMD_LO && a <= panel_pkg::CMD_HI) sect = 3'h3;
        if (a >= panel_pkg::PROG_LO && a <= panel_pkg::PROG_HI) sect = 3'h4;
        if (a >= panel_pkg::SEC_LO && a <= panel_pkg::SEC_HI) sect = 3'h5;
    endfunction : sect
    function automatic logic [31:0] whq(input logic [11:0] v, input logic c);
        if (v >= panel_pkg::VOLT_SPLIT) whq = c ? panel_pkg::WH_HIGH_CL2 : panel_pkg::WH_HIGH_CL10;
        else whq = c ? panel_pkg::WH_LOW_CL2 : panel_pkg::WH_LOW_CL10;
    endfunction : whq
    // current pulse length
    always_ff @(posedge core_clk) begin
        if (rst || !test_pulse) hi_len <= '0;
        else hi_len <= hi_len + 32'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    reset_clear_a: assert property ($past(rst) |-> disp_mode == 2'h0
        && active_group == 3'h0 && load_bar == 10'h000 && !test_pulse && group_lamp == 8'h01)
        else $error("state not cleared by reset");
    lamp_onehot_a: assert property (disp_mode == 2'h0 |->
        group_lamp == (8'h01 << active_group)) else $error("lamp not one-hot of group");
    lamp_off_a: assert property (disp_mode != 2'h0 |-> group_lamp == 8'h00)
        else $error("lamp lit outside operating mode");
    group_freeze_a: assert property (disp_mode != 2'h0 && $past(disp_mode) != 2'h0
        |-> $stable(active_group)) else $error("group moved outside operating mode");
    bar_level_a: assert property (!$past(rst) && $past(load_pct) <= 8'h78
        |-> load_bar == therm($past(load_pct))) else $error("bar level wrong");
    bar_blink_a: assert property (!$past(rst) && $past(load_pct) > 8'h78
        |-> load_bar inside {10'h000, 10'h3ff}) else $error("overload bar not all or none");
    pulse_start_a: assert property (energy_quantum && !test_pulse |=> test_pulse)
        else $error("quantum gave no pulse");
    pulse_width_a: assert property ($fell(test_pulse)
        |-> hi_len >= 32'(PULSE_MIN_MS * TICK_CYCLES)) else $error("test pulse too short");
    blank_span_a: assert property ($rose(disp_blank)
        |-> disp_blank [*8] ##1 !disp_blank) else $error("blank pause length wrong");
    quantum_pick_a: assert property ($stable(input_volts) && $stable(class_two)
        && !$past(rst) |-> watt_hour_per_pulse_constant == whq(input_volts, class_two))
        else $error("pulse quantum wrong");
    text_pack_a: assert property (!$past(rst) |-> text_word == $past(text_chars))
        else $error("text word wrong");
    word_pack_a: assert property (!$past(rst)
        |-> {hi_word, lo_word} == $past(value32)) else $error("word halves wrong");
    section_map_a: assert property (!$past(rst)
        |-> reg_section == sect($past(reg_addr))) else $error("register section wrong");
    cover property ($rose(test_pulse));
    cover property ($fell(disp_blank));
    cover property (load_bar == 10'h3ff && load_pct > 8'h78);
    cover property ($past(disp_mode) != 2'h0 && disp_mode == 2'h0);
endmodule : panel_properties
bind meter_front_panel_display panel_properties #(.TICK_CYCLES(TICK_CYCLES),
    .PULSE_MIN_MS(PULSE_MIN_MS)) u_props (.*);
`default_nettype wire

/* File: tb/panel_user.sv */
// partner: front panel user and accuracy test standard
`timescale 1ns/1ns
`default_nettype none
module panel_user (
    input wire logic core_clk,
    input wire logic test_pulse,
    output logic btn_down,
    output logic btn_right,
    output logic btn_any,
    output logic energy_quantum
);
    int widths[$];
    int run = 0;
    initial begin
        btn_down = 1'b0;
        btn_right = 1'b0;
        btn_any = 1'b0;
        energy_quantum = 1'b0;
    end
    // standard measures each pulse width
    always @(posedge core_clk) begin
        if (test_pulse === 1'b1) begin
            run++;
        end else if (run != 0) begin
            widths.push_back(run);
            run = 0;
        end
    end
    // 0 down, 1 right, else any
    task automatic press(input int which);
        @(posedge core_clk);
        btn_down <= (which == 0);
        btn_right <= (which == 1);
        btn_any <= 1'b1;
        repeat (4) @(posedge core_clk);
        btn_down <= 1'b0;
        btn_right <= 1'b0;
        btn_any <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : press
    task automatic quantum();
        @(posedge core_clk);
        energy_quantum <= 1'b1;
        @(posedge core_clk);
        energy_quantum <= 1'b0;
    endtask : quantum
endmodule : panel_user
`default_nettype wire

/* File: tb/tb.sv */
// testbench: front panel display against a behavioural model
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int TK = 4;
    localparam int SHOW = 7;
    localparam int PAUSE = 2;
    localparam int PW = 2;
    logic core_clk, rst, btn_down, btn_right, btn_any, mode_request, scroll_enable;
    logic class_two, energy_quantum, disp_blank, test_pulse;
    logic [1:0] mode_select, disp_mode;
    logic [7:0] group_enable, load_pct, group_lamp;
    logic [39:0] sub_enable, se;
    logic [11:0] input_volts;
    logic [15:0] text_chars, reg_addr, text_word, hi_word, lo_word, rt;
    logic [31:0] value32, watt_hour_per_pulse_constant, rv;
    logic [2:0] active_group, active_sub, reg_section;
    logic [9:0] load_bar;
    int n_fail = 0, n_compared = 0, g, s, n, ra, on_n, off_n;
    int th[10] = '{1, 15, 30, 45, 60, 72, 84, 96, 108, 120};
    int vt[4] = '{100, 149, 150, 400};
    int lim[20] = '{0, 1, 47, 48, 999, 1000, 5003, 5004, 19999, 20000, 26011, 26012,
        29999, 30000, 30067, 30068, 40000, 40001, 40100, 40101};
    meter_front_panel_display #(.TICK_CYCLES(TK), .SHOW_MS(SHOW), .PAUSE_MS(PAUSE),
        .SCROLL_HOLD_MS(20), .IDLE_MS(30), .BLINK_ON_MS(3), .BLINK_OFF_MS(2),
        .PULSE_MIN_MS(PW)) dut (.*);
    panel_user u_user (.*);
    function automatic int nxt(input int g0, input logic [7:0] en);
        int k;
        k = g0;
        for (int i = 0; i < 8; i++) begin
            k = (k + 1) % 8;
            if (en[k]) return k;
        end
        return g0;
    endfunction : nxt
    function automatic int nsub(input int gg, input int s0, input logic [39:0] en);
        int k;
        k = s0;
        for (int i = 0; i < 5; i++) begin
            k = (k + 1) % int'(panel_pkg::SUB_COUNT[gg]);
            if (en[gg * 5 + k]) return k;
        end
        return s0;
    endfunction : nsub
    function automatic int sect(input int a);
        for (int j = 0; j < 5; j++) if (a >= lim[4 * j + 1] && a <= lim[4 * j + 2]) return j + 1;
        return 0;
    endfunction : sect
    function automatic logic [31:0] wq(input int v, input bit c);
        if (v >= 150) return c ? panel_pkg::WH_HIGH_CL2 : panel_pkg::WH_HIGH_CL10;
        return c ? panel_pkg::WH_LOW_CL2 : panel_pkg::WH_LOW_CL10;
    endfunction : wq
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic results();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic wait_blank(input logic lvl, output int k);
        k = 0;
        while (disp_blank !== lvl && k < 500) begin
            tick(1);
            k++;
        end
        if (k >= 500) chk("blank_wait", 0, 1);
    endtask : wait_blank
    task automatic rst_chk();
        @(posedge core_clk);
        rst <= 1'b1;
        tick(6);
        chk("mode", 0, disp_mode);
        chk("group", 0, active_group);
        chk("lamp", 1, group_lamp);
        chk("bar", 0, load_bar);
        chk("pulse", 0, test_pulse);
        chk("blank", 0, disp_blank);
        @(posedge core_clk);
        rst <= 1'b0;
    endtask : rst_chk
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        results();
    end
    initial begin
        {rst, mode_request, mode_select, scroll_enable, class_two} = 6'h20;
        {group_enable, sub_enable, load_pct} = {8'hff, 40'hff_ffff_ffff, 8'h00};
        {input_volts, text_chars, value32, reg_addr} = '0;
        void'($urandom(73));
        rst_chk();
        for (int i = 0; i < 40; i++) begin
            rv = $urandom;
            rt = 16'($urandom);
            ra = (i < 20) ? lim[i] : int'($urandom % 65536);
            @(posedge core_clk);
            value32 <= rv;
            text_chars <= rt;
            reg_addr <= 16'(ra);
            tick(1);
            chk("text", rt, text_word);
            chk("words", rv, {hi_word, lo_word});
            chk("sect", sect(ra), reg_section);
        end
        for (int i = 0; i < 8; i++) begin
            rv = $urandom;
            if (i < 4) rv[11:0] = 12'(vt[i]);
            @(posedge core_clk);
            input_volts <= rv[11:0];
            class_two <= rv[12];
            tick(2);
            chk("quantum", wq(rv[11:0], rv[12]), watt_hour_per_pulse_constant);
        end
        for (int i = 0; i < 30; i++) begin
            n = (i >= 20) ? int'($urandom % 121) : (i % 2) ? th[i / 2] : th[i / 2] - 1;
            @(posedge core_clk);
            load_pct <= 8'(n);
            tick(2);
            on_n = 0;
            foreach (th[k]) if (n >= th[k]) on_n++;
            chk("bar", (1 << on_n) - 1, load_bar);
        end
        @(posedge core_clk);
        load_pct <= 8'h79;
        tick(30);
        on_n = 0;
        off_n = 0;
        repeat (100) begin
            if (load_bar === 10'h3ff) on_n++;
            else if (load_bar === 10'h000) off_n++;
            tick(1);
        end
        chk("blink_on", 60, on_n);
        chk("blink_off", 40, off_n);
        u_user.quantum();
        repeat (2) @(posedge core_clk);
        u_user.quantum();
        repeat (12) @(posedge core_clk);
        u_user.quantum();
        repeat (14) @(posedge core_clk);
        chk("pulses", 2, u_user.widths.size());
        foreach (u_user.widths[k]) chk("width", PW * TK, u_user.widths[k]);
        for (int i = 0; i < 16; i++) begin
            if (i == 8) begin
                @(posedge core_clk);
                group_enable <= 8'($urandom);
            end
            u_user.press(0);
            g = nxt(g, group_enable);
            #1;
            chk("group", g, active_group);
            chk("lamp", 1 << g, group_lamp);
        end
        se = ~(40'h1 << (g * 5 + 1));
        @(posedge core_clk);
        sub_enable <= se;
        s = 0;
        for (int i = 0; i < 4; i++) begin
            u_user.press(1);
            s = nsub(g, s, se);
            #1;
            chk("sub", s, active_sub);
        end
        for (int m = 1; m < 4; m++) begin
            @(posedge core_clk);
            mode_request <= 1'b1;
            mode_select <= 2'(m);
            @(posedge core_clk);
            mode_request <= 1'b0;
            tick(2);
            chk("mode", m, disp_mode);
            chk("lamp_off", 0, group_lamp);
            u_user.press(0);
            #1;
            chk("no_down", g, active_group);
            repeat (80) @(posedge core_clk);
            u_user.press(2);
            n = 0;
            while (disp_mode !== 2'h0 && n < 300) begin
                tick(1);
                n++;
            end
            chk("idle_back", 1, n >= 100 && n <= 130);
        end
        @(posedge core_clk);
        scroll_enable <= 1'b1;
        wait_blank(1'b1, n);
        wait_blank(1'b0, n);
        g = nxt(g, group_enable);
        chk("blank_len", PAUSE * TK, n);
        chk("scroll_grp", g, active_group);
        wait_blank(1'b1, n);
        chk("show_len", SHOW * TK, n);
        wait_blank(1'b0, n);
        g = nxt(g, group_enable);
        u_user.press(2);
        wait_blank(1'b1, n);
        chk("hold", 1, n > 60 && n < 120);
        chk("held_grp", g, active_group);
        wait_blank(1'b0, n);
        @(posedge core_clk);
        scroll_enable <= 1'b0;
        rst_chk();
        results();
    end
endmodule : tb
`default_nettype wire
